// ==== shared/exd_pkg.sv ====
// Purpose: constants shared by the extended instruction decode/execute block
// Assumes: one clock cycle stands for one instruction cycle
// Notes:   opcode fields sit in the upper byte of the instruction word, except the full-word register call

// ************************************************************
// package
// ************************************************************
package exd_pkg;
   // opcode upper bytes of the literal forms, the full register call word and the second word nibble
   localparam logic [7:0]  OP_ADDP    = 8'hE8;
   localparam logic [7:0]  OP_SUBP    = 8'hE9;
   localparam logic [7:0]  OP_PUSH_LIT = 8'hEA;
   localparam logic [7:0]  OP_MOVE    = 8'hEB;
   localparam logic [15:0] OP_CALL_WORK = 16'h0014;
   localparam logic [3:0]  SECOND_NIB = 4'hF;
   // pointer select codes
   localparam logic [1:0]  SEL_FRAME  = 2'h3;
   localparam logic [1:0]  FRAME_IDX  = 2'h2;
   // indexed literal offset window upper bound
   localparam logic [7:0]  IDX_LIMIT  = 8'h5F;
   // indirect access register groups, one per pointer, five each
   localparam logic [2:0][11:0] IND_BASE = {12'hFDB, 12'hFE3, 12'hFEB};
   localparam logic [11:0] IND_SPAN   = 12'h005;
   localparam logic [11:0] PTR_RST    = 12'h000;
   localparam logic [11:0] PUSH_STEP  = 12'h001;
   // cycles taken by the multi-cycle forms
   localparam int          CYC_RET    = 2;
   localparam int          CYC_MOVE   = 2;

   typedef enum logic [2:0]
   {
      ST_EXEC = 3'b001,
      ST_NOP  = 3'b010,
      ST_MOVE = 3'b100
   } exd_state_e;
endpackage

// ==== shared/exd_dec_if.sv ====
// Purpose: carries the instruction word and its decoded classes
// Assumes: decode is purely combinational
// Notes:   the decoder drives all class flags

`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// decode interface
// ************************************************************
interface exd_dec_if;
   logic [15:0] instr;
   logic        ext_en;
   logic        is_addp;
   logic        is_subp;
   logic        is_ret;
   logic        is_call_reg;
   logic        is_push_lit;
   logic        is_move;
   logic        is_second;
   logic [1:0]  sel;
   logic [5:0]  lit6;
   logic [6:0]  zoff;

   modport dec (input instr, ext_en, output is_addp, is_subp, is_ret,
                is_call_reg, is_push_lit, is_move, is_second, sel,
                lit6, zoff);
   modport use_ (input is_addp, is_subp, is_ret, is_call_reg, is_push_lit,
                 is_move, is_second, sel, lit6, zoff,
                 output instr, ext_en);
endinterface // exd_dec_if

`default_nettype wire

// ==== src/exd_decode.sv ====
// Purpose: classify an instruction word into the extended forms
// Assumes: ext_en is the captured enable bit
// Notes:   all classes read zero while the extension is off

`timescale 1ns/1ps
`default_nettype none

module exd_decode
(
   exd_dec_if.dec d
);
   wire [7:0] hi = d.instr[15:8];
   wire       en = d.ext_en;

   // ************************************************************
   // opcode classes
   // ************************************************************
   assign d.sel       = d.instr[7:6];
   assign d.lit6      = d.instr[5:0];
   assign d.zoff      = d.instr[6:0];
   assign d.is_addp   = en & (hi == exd_pkg::OP_ADDP);
   assign d.is_subp   = en & (hi == exd_pkg::OP_SUBP);
   // select code 3 turns add/sub into the frame-and-return form
   assign d.is_ret    = (d.is_addp | d.is_subp)
                        & (d.sel == exd_pkg::SEL_FRAME);
   assign d.is_call_reg = en & (d.instr == exd_pkg::OP_CALL_WORK);
   assign d.is_push_lit = en & (hi == exd_pkg::OP_PUSH_LIT);
   assign d.is_move   = en & (hi == exd_pkg::OP_MOVE);
   assign d.is_second = en & (d.instr[15:12] == exd_pkg::SECOND_NIB);
endmodule // exd_decode

`default_nettype wire

// ==== src/exd_top.sv ====
// Purpose: decode and execute of the extended literal instructions
// Assumes: one clock per instruction cycle, inputs synchronous
// Notes:   the three file-select pointers live here; the core may
//          overwrite them through the pointer write port
//
// Behaviour
// - Extension stays off unless enable bit set
// - Decode exactly eight added literal instructions
// - Indexed literal offset addressing for standard ops
// - Add 6-bit literal to pointer, one cycle
// - Select 3 add: frame add then return
// - Subtract 6-bit literal from pointer, one cycle
// - Select 3 subtract: frame subtract then return
// - Register call opcode is a two-cycle call
// - Push literal at frame, then decrement frame
// - Return loads stack top, second cycle idles
// - Call pushes next address, target from latches and working register
// - Indexed mode when access bit clear, f<=95
// - Indirect register as move source reads zero

`timescale 1ns/1ps
`default_nettype none

module exd_top
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // configuration
   input  wire logic              ext_set_enable_bit,
   // fetch side
   input  wire logic [15:0]       instr_word,
   input  wire logic              instr_valid,
   input  wire logic              std_file_op,
   // core registers
   input  wire logic [7:0]        working_register,
   input  wire logic [7:0]        prog_counter_high_latch,
   input  wire logic [4:0]        prog_counter_upper_latch,
   input  wire logic [20:0]       return_stack_top,
   input  wire logic [20:0]       next_pc,
   // pointer write from the core
   input  wire logic [2:0]        ptr_wr_en,
   input  wire logic [11:0]       ptr_wr_data,
   // data memory
   input  wire logic [7:0]        mem_rdata,
   output logic      [11:0]       mem_addr,
   output logic      [7:0]        mem_wdata,
   output logic                   mem_we,
   output logic                   mem_re,
   // program counter and return stack
   output logic                   pc_load,
   output logic      [20:0]       pc_target,
   output logic                   stack_push,
   output logic      [20:0]       stack_data,
   // pointers, operand address and status
   output logic      [2:0][11:0]  file_select_pointer,
   output logic      [11:0]       oper_addr,
   output logic                   oper_indexed,
   output logic                   ext_active,
   output logic                   busy
);
   exd_dec_if d ();
   exd_decode u_dec (.d(d));

   exd_pkg::exd_state_e state_q, state_d;
   logic [2:0][11:0] fsp_q;
   logic        ext_en_q, cap_q;
   logic [11:0] mem_addr_q, oper_addr_q;
   logic [7:0]  mem_wdata_q;
   logic        mem_we_q, mem_re_q, pc_load_q, push_q, oper_idx_q;
   logic [20:0] pc_target_q, stack_data_q;
   logic        move_ss_q, src_ind_q;
   logic [2:0]  ind_hit;

   // ************************************************************
   // decode hookup and qualified events
   // ************************************************************
   assign d.instr  = instr_word;
   assign d.ext_en = ext_en_q;
   wire exec_go   = instr_valid & (state_q == exd_pkg::ST_EXEC);
   wire do_ret    = exec_go & d.is_ret;
   wire do_call   = exec_go & d.is_call_reg;
   wire do_push   = exec_go & d.is_push_lit;
   wire do_move   = exec_go & d.is_move;
   wire do_ptr    = exec_go & (d.is_addp | d.is_subp);
   wire move_wr   = state_q == exd_pkg::ST_MOVE;
   // select code 3 always means the frame pointer
   wire [1:0] psel = d.is_ret ? exd_pkg::FRAME_IDX : d.sel;
   wire       ptr_down = d.is_subp | d.is_push_lit;
   wire [11:0] amt = d.is_push_lit ? exd_pkg::PUSH_STEP
                                : {6'h00, d.lit6};
   wire [11:0] frame = fsp_q[exd_pkg::FRAME_IDX];
   wire [11:0] src_addr = frame + {5'h00, d.zoff};
   // second word destination: absolute, or frame relative for move_ss
   wire [11:0] dst_addr = move_ss_q ? frame + {5'h00, instr_word[6:0]}
                                    : instr_word[11:0];
   wire [7:0]  fld = instr_word[7:0];
   wire idx_mode = ext_en_q & std_file_op & ~instr_word[8]
                   & (fld <= exd_pkg::IDX_LIMIT);

   // ************************************************************
   // per pointer update and indirect source check
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_ptr
         wire hit = (do_ptr & (psel == 2'(gi)))
                    | (do_push & (gi == 2));
         assign ind_hit[gi] = (src_addr - exd_pkg::IND_BASE[gi])
                              < exd_pkg::IND_SPAN;
         // the core's own write to a pointer takes precedence
         always_ff @(posedge clock or negedge nrst)
         begin
            if (!nrst)
               fsp_q[gi] <= exd_pkg::PTR_RST;
            else if (ptr_wr_en[gi])
               fsp_q[gi] <= ptr_wr_data;
            else if (hit)
               fsp_q[gi] <= ptr_down ? fsp_q[gi] - amt
                                     : fsp_q[gi] + amt;
         end
      end
   endgenerate

   // ************************************************************
   // enable capture
   // ************************************************************
   // the bit is sampled once after reset release, like a fuse
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ext_en_q <= 1'b0;
         cap_q    <= 1'b0;
      end
      else if (!cap_q)
      begin
         ext_en_q <= ext_set_enable_bit;
         cap_q    <= 1'b1;
      end
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb
   begin
      state_d = exd_pkg::ST_EXEC;
      unique case (state_q)
         exd_pkg::ST_EXEC:
            if (do_ret | do_call)
               state_d = exd_pkg::ST_NOP;
            else if (do_move)
               state_d = exd_pkg::ST_MOVE;
         exd_pkg::ST_NOP:  state_d = exd_pkg::ST_EXEC;
         exd_pkg::ST_MOVE: state_d = exd_pkg::ST_EXEC;
         default:          state_d = exd_pkg::ST_EXEC;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         state_q <= exd_pkg::ST_EXEC;
      else
         state_q <= state_d;
   end

   // ************************************************************
   // move bookkeeping between the two words
   // ************************************************************
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         move_ss_q <= 1'b0;
         src_ind_q <= 1'b0;
      end
      else if (do_move)
      begin
         move_ss_q <= instr_word[7];
         src_ind_q <= |ind_hit;
      end
   end

   // ************************************************************
   // data memory port
   // ************************************************************
   // one registered port: the read of a move and its write are one
   // cycle apart so they never collide with a following push
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_addr_q  <= 12'h000;
         mem_wdata_q <= 8'h00;
         mem_we_q    <= 1'b0;
         mem_re_q    <= 1'b0;
      end
      else
      begin
         mem_we_q <= do_push | move_wr;
         mem_re_q <= do_move;
         if (do_push)
         begin
            mem_addr_q  <= frame;
            mem_wdata_q <= instr_word[7:0];
         end
         else if (do_move)
            mem_addr_q  <= src_addr;
         else if (move_wr)
         begin
            mem_addr_q  <= dst_addr;
            mem_wdata_q <= src_ind_q ? 8'h00 : mem_rdata;
         end
      end
   end

   // ************************************************************
   // program counter and return stack
   // ************************************************************
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pc_load_q    <= 1'b0;
         pc_target_q  <= 21'h00000;
         push_q       <= 1'b0;
         stack_data_q <= 21'h00000;
      end
      else
      begin
         pc_load_q <= do_ret | do_call;
         push_q    <= do_call;
         if (do_ret)
            pc_target_q <= return_stack_top;
         else if (do_call)
            pc_target_q <= {prog_counter_upper_latch,
                            prog_counter_high_latch,
                            working_register};
         if (do_call)
            stack_data_q <= next_pc;
      end
   end

   // ************************************************************
   // operand address of standard file instructions
   // ************************************************************
   // a second word in EXEC falls through every branch: a no-operation
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         oper_addr_q <= 12'h000;
         oper_idx_q  <= 1'b0;
      end
      else if (exec_go & std_file_op & ~d.is_second)
      begin
         oper_idx_q  <= idx_mode;
         oper_addr_q <= idx_mode ? frame + {4'h0, fld}
                                 : {4'h0, fld};
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign mem_addr            = mem_addr_q;
   assign mem_wdata           = mem_wdata_q;
   assign mem_we              = mem_we_q;
   assign mem_re              = mem_re_q;
   assign pc_load             = pc_load_q;
   assign pc_target           = pc_target_q;
   assign stack_push          = push_q;
   assign stack_data          = stack_data_q;
   assign file_select_pointer = fsp_q;
   assign oper_addr           = oper_addr_q;
   assign oper_indexed        = oper_idx_q;
   assign ext_active          = ext_en_q;
   assign busy                = ~state_q[0];

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   ext_off_quiet_a: assert property (cap_q & !ext_en_q |=>
      !stack_push & !mem_re & !pc_load)
      else $error("extended action while disabled");
   ptr_add_a: assert property (do_ptr & d.is_addp & d.sel == 2'h0
      & !ptr_wr_en[0] |=> fsp_q[0] == $past(fsp_q[0]) + $past(amt))
      else $error("pointer add wrong");
   ptr_sub_a: assert property (do_ptr & d.is_subp & d.sel == 2'h1
      & !ptr_wr_en[1] |=> fsp_q[1] == $past(fsp_q[1]) - $past(amt))
      else $error("pointer subtract wrong");
   ret_two_cyc_a: assert property (do_ret |=> pc_load
      & pc_target == $past(return_stack_top) & busy
      ##1 !pc_load & !busy)
      else $error("return form not two cycles");
   call_push_a: assert property (do_call |=> stack_push
      & stack_data == $past(next_pc)
      & pc_target[7:0] == $past(working_register))
      else $error("register call wrong");
   push_lit_a: assert property (do_push & !ptr_wr_en[2] |=>
      mem_we & mem_addr == $past(frame)
      & mem_wdata == $past(instr_word[7:0])
      & fsp_q[2] == $past(frame) - 12'h001)
      else $error("literal push wrong");
   move_seq_a: assert property (do_move |=> mem_re & busy
      ##1 mem_we & !mem_re)
      else $error("move sequence wrong");
   ind_zero_a: assert property (move_wr & src_ind_q |=>
      mem_we & mem_wdata == 8'h00)
      else $error("indirect source not zero");
   idx_addr_a: assert property (exec_go & idx_mode & !d.is_second
      |=> oper_indexed
      & oper_addr == $past(frame) + {4'h0, $past(fld)})
      else $error("indexed operand address wrong");
   second_nop_a: assert property (exec_go & d.is_second |=>
      !mem_we & !pc_load & !stack_push & !busy)
      else $error("lone second word not idle");

   ret_c: cover property (do_ret ##2 exec_go);
   call_c: cover property (do_call ##1 stack_push);
   move_c: cover property (do_move ##1 move_wr ##1 mem_we);
endmodule // exd_top

`default_nettype wire

// ==== bench/exd_top_tb.sv ====
// Purpose: self-checking bench for the extended decode/execute block
// Assumes: one rising edge of clock per instruction cycle
// Notes:   the bench keeps its own copy of the three pointers

`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// bench
// ************************************************************
module exd_top_tb;
   logic              clock;
   logic              nrst;
   logic              ext_set_enable_bit;
   logic [15:0]       instr_word;
   logic              instr_valid;
   logic              std_file_op;
   logic [7:0]        work_reg;
   logic [7:0]        hlatch;
   logic [4:0]        ulatch;
   logic [20:0]       stack_top;
   logic [20:0]       npc;
   logic [2:0]        ptr_wr_en;
   logic [11:0]       ptr_wr_data;
   logic [7:0]        mem_rdata;
   logic [11:0]       mem_addr;
   logic [7:0]        mem_wdata;
   logic              mem_we;
   logic              mem_re;
   logic              pc_load;
   logic [20:0]       pc_target;
   logic              stack_push;
   logic [20:0]       stack_data;
   logic [2:0][11:0]  fsp;
   logic [11:0]       oper_addr;
   logic              oper_indexed;
   logic              ext_active;
   logic              busy;
   logic [11:0]       fp [0:2];
   int                num_errors;
   int                check_count;

   exd_top dut
   (
      .clock                    (clock),
      .nrst                     (nrst),
      .ext_set_enable_bit       (ext_set_enable_bit),
      .instr_word               (instr_word),
      .instr_valid              (instr_valid),
      .std_file_op              (std_file_op),
      .working_register         (work_reg),
      .prog_counter_high_latch  (hlatch),
      .prog_counter_upper_latch (ulatch),
      .return_stack_top         (stack_top),
      .next_pc                  (npc),
      .ptr_wr_en                (ptr_wr_en),
      .ptr_wr_data              (ptr_wr_data),
      .mem_rdata                (mem_rdata),
      .mem_addr                 (mem_addr),
      .mem_wdata                (mem_wdata),
      .mem_we                   (mem_we),
      .mem_re                   (mem_re),
      .pc_load                  (pc_load),
      .pc_target                (pc_target),
      .stack_push               (stack_push),
      .stack_data               (stack_data),
      .file_select_pointer      (fsp),
      .oper_addr                (oper_addr),
      .oper_indexed             (oper_indexed),
      .ext_active               (ext_active),
      .busy                     (busy)
   );

   // 10 MHz clock
   always #50 clock = ~clock;

   // ************************************************************
   // expectation functions and drivers
   // ************************************************************
   function automatic logic [11:0] exp_ptr(input logic s,
      input logic [11:0] p, input logic [5:0] k);
      return s ? p - {6'h00, k} : p + {6'h00, k};
   endfunction

   // indexed only for access bank with f inside the low window
   function automatic logic [12:0] exp_oper(input logic a,
      input logic [7:0] f);
      if (!a && f <= exd_pkg::IDX_LIMIT)
         return {1'b1, fp[2] + {4'h0, f}};
      return {1'b0, 4'h0, f};
   endfunction

   task automatic chk(input logic [20:0] got, input logic [20:0] exp,
      input string m);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got,
            exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // w2 follows at the taking edge, so a move sees its second word
   task automatic issue(input logic [15:0] w, input logic sf,
      input logic [15:0] w2);
      @(posedge clock);
      instr_word  <= w;
      instr_valid <= 1'b1;
      std_file_op <= sf;
      work_reg    <= 8'($urandom);
      hlatch      <= 8'($urandom);
      ulatch      <= 5'($urandom);
      stack_top   <= 21'($urandom);
      npc         <= 21'($urandom);
      @(posedge clock);
      instr_word  <= w2;
      instr_valid <= 1'b0;
      std_file_op <= 1'b0;
      #1;
   endtask

   task automatic do_reset(input logic en);
      @(posedge clock);
      nrst               <= 1'b0;
      ext_set_enable_bit <= en;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      fp = '{3{12'h000}};
      chk(ext_active, en, "enable capture");
      chk(fsp[2], 12'h000, "pointer reset");
   endtask

   task automatic setp(input int i, input logic [11:0] v);
      @(posedge clock);
      ptr_wr_en   <= 3'(3'b001 << i);
      ptr_wr_data <= v;
      @(posedge clock);
      ptr_wr_en <= 3'b000;
      fp[i] = v;
      #1;
      chk(fsp[i], v, "pointer load");
   endtask

   task automatic addsub(input logic s, input logic [1:0] f,
      input logic [5:0] k);
      issue({s ? exd_pkg::OP_SUBP : exd_pkg::OP_ADDP, f, k}, 1'b0, 16'h0);
      fp[f] = exp_ptr(s, fp[f], k);
      chk(fsp[f], fp[f], "pointer add/sub");
      chk(busy, 1'b0, "one cycle form");
   endtask

   // data is read at frame plus zs, written one cycle later
   task automatic move(input logic rel, input logic [6:0] zs,
      input logic [11:0] d, input logic [7:0] dat, input logic [7:0] ed);
      @(posedge clock);
      mem_rdata <= dat;
      issue({exd_pkg::OP_MOVE, rel, zs}, 1'b0,
         rel ? {4'hF, 5'h00, d[6:0]} : {4'hF, d});
      chk(mem_re, 1'b1, "move read");
      chk(mem_addr, fp[2] + {5'h00, zs}, "move source");
      chk(busy, 1'b1, "move busy");
      @(posedge clock);
      #1;
      chk(mem_we, 1'b1, "move write");
      chk(mem_addr, rel ? fp[2] + {5'h00, d[6:0]} : d, "move dest");
      chk(mem_wdata, ed, "move data");
   endtask

   // ************************************************************
   // tests
   // ************************************************************
   initial
   begin
      logic [7:0] fs [4];
      logic       as [4];
      logic [5:0] k;
      logic [7:0] lit8;
      clock = 1'b0; nrst = 1'b0; ext_set_enable_bit = 1'b0;
      fs = '{8'h5F, 8'h60, 8'h0A, 8'h00};
      as = '{1'b0, 1'b0, 1'b1, 1'b0};
      instr_word = 16'h0000; instr_valid = 1'b0; std_file_op = 1'b0;
      work_reg = 8'h00; hlatch = 8'h00; ulatch = 5'h00; stack_top = 21'h0;
      npc = 21'h0; ptr_wr_en = 3'b000; ptr_wr_data = 12'h000;
      mem_rdata = 8'h00; num_errors = 0; check_count = 0;
      void'($urandom(32'hBF95A74E));
      do_reset(1'b0);
      issue({exd_pkg::OP_ADDP, 2'h0, 6'h05}, 1'b0, 16'h0);
      chk(fsp[0], 12'h000, "add while off");
      issue(exd_pkg::OP_CALL_WORK, 1'b0, 16'h0);
      chk(pc_load, 1'b0, "call while off");
      issue({7'b0110011, 1'b0, 8'h10}, 1'b1, 16'h0);
      chk(oper_indexed, 1'b0, "indexed while off");
      $display("test extension off done");
      do_reset(1'b1);
      ext_set_enable_bit <= 1'b0;
      for (int i = 0; i < 3; i++) setp(i, 12'($urandom));
      setp(1, 12'hFFF);
      addsub(1'b0, 2'h1, 6'h3F);
      setp(0, 12'h000);
      addsub(1'b1, 2'h0, 6'h3F);
      for (int i = 0; i < 16; i++)
         addsub(1'($urandom), 2'($urandom_range(2, 0)), 6'($urandom));
      $display("test pointer add and subtract done");
      for (int s = 0; s < 2; s++)
      begin
         k = 6'($urandom);
         issue({s ? exd_pkg::OP_SUBP : exd_pkg::OP_ADDP, 2'h3, k}, 1'b0,
            16'h0);
         fp[2] = exp_ptr(1'(s), fp[2], k);
         chk(fsp[2], fp[2], "frame update");
         chk(pc_load, 1'b1, "return load");
         chk(pc_target, stack_top, "return target");
         chk(busy, 1'b1, "return busy");
         @(posedge clock);
         #1;
         chk({pc_load, busy}, 2'b00, "return idle cycle");
      end
      issue(exd_pkg::OP_CALL_WORK, 1'b0, 16'h0);
      chk({stack_push, pc_load, busy}, 3'b111, "call strobes");
      chk(stack_data, npc, "call push");
      chk(pc_target, {ulatch, hlatch, work_reg}, "call target");
      $display("test return and call done");
      for (int i = 0; i < 2; i++)
      begin
         lit8 = 8'($urandom);
         issue({exd_pkg::OP_PUSH_LIT, lit8}, 1'b0, 16'h0);
         chk(mem_we, 1'b1, "push write");
         chk(mem_addr, fp[2], "push addr");
         chk(mem_wdata, lit8, "push data");
         fp[2] = fp[2] - exd_pkg::PUSH_STEP;
         chk(fsp[2], fp[2], "push decrement");
      end
      $display("test push done");
      setp(2, 12'($urandom_range(12'hF00, 0)));
      move(1'b0, 7'($urandom), 12'($urandom), 8'h5A, 8'h5A);
      move(1'b1, 7'h7F, 12'h07F, 8'hC3, 8'hC3);
      setp(2, exd_pkg::IND_BASE[0] - 12'h003);
      move(1'b0, 7'h03, 12'h123, 8'hA5, 8'h00);
      setp(2, exd_pkg::IND_BASE[2] - 12'h00A);
      move(1'b0, 7'h0E, 12'h124, 8'hA5, 8'h00);
      move(1'b0, 7'h0F, 12'h125, 8'h96, 8'h96);
      $display("test indexed move done");
      issue(16'hF123, 1'b0, 16'h0);
      chk({mem_we, mem_re, pc_load, busy}, 4'h0, "lone second");
      chk(fsp[2], fp[2], "lone second frame");
      for (int i = 0; i < 4; i++)
      begin
         issue({7'b0110011, as[i], fs[i]}, 1'b1, 16'h0);
         chk({oper_indexed, oper_addr},
            exp_oper(as[i], fs[i]), "oper");
      end
      chk(ext_active, 1'b1, "enable held");
      $display("test standard operand done");
      tally_and_finish();
   end

   // watchdog cuts a hang far beyond the expected run
   initial
   begin
      #500000;
      num_errors++;
      tally_and_finish();
   end
endmodule // exd_top_tb

`default_nettype wire
